// ===== rtl/io_group_pkg.sv
// Purpose: Constants and types for the I/O instruction group executor
// Assumes: 16-bit instruction words, 64 select codes
// Notes: Register map of the AHB-Lite slave lives here too
//
// How it works
// RULE_01 - Bits 5..0 pick one of 64 channels
// RULE_02 - Bit 9 set clears channel flag after
// RULE_03 - Bits 8..6 pick op; bit 11 A/B
// RULE_04 - Overflow tests: bit 9 clears overflow
// RULE_05 - Halt stops, flag per bit 9, PC+1
// RULE_06 - Set flag; code 00 enables interrupts
// RULE_07 - Clear flag; code 00 disables interrupts
// RULE_08 - Skip when addressed flag clear
// RULE_09 - Skip when addressed flag set
// RULE_10 - Merge buffer into accumulator by OR
// RULE_11 - Load buffer into accumulator
// RULE_12 - Output accumulator to buffer, unchanged accumulator
// RULE_13 - Set control sets channel control bit
// RULE_14 - Clear control; code 00 clears 06 up
// RULE_15 - Set and clear the overflow bit
// RULE_16 - Skip when overflow is one
// RULE_17 - Skip when overflow is zero
// RULE_18 - Taken skip advances PC by two
package io_group_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned CHAN_N = 64;
	localparam int unsigned SEL_W = 6;
	localparam int unsigned BIT_AB = 11;
	localparam int unsigned BIT_HC = 9;
	localparam logic [5:0] SEL_SYSTEM = 6'h00;
	localparam logic [5:0] SEL_FIRST_DEV = 6'h06;
	localparam logic [5:0] SEL_OVF_FN = 6'h01;

	// Operation field, bits 8..6
	typedef enum logic [2:0] {
		op_halt_or_flag = 3'h0,
		op_skip_clear = 3'h2,
		op_skip_set = 3'h3,
		op_merge = 3'h4,
		op_load = 3'h5,
		op_output = 3'h6,
		op_control = 3'h7,
		op_overflow = 3'h1
	} io_op_e;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC_A = 8'h04;
	localparam logic [7:0] OFS_ACC_B = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_FLAG_LO = 8'h14;
	localparam logic [7:0] OFS_FLAG_HI = 8'h18;
	localparam logic [7:0] OFS_CTRL_LO = 8'h1c;
	localparam logic [7:0] OFS_CTRL_HI = 8'h20;
	localparam logic [7:0] OFS_RUN = 8'h24;

	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [15:0] word;
		logic [5:0] sel;
		logic write;
	} chan_req_s;

	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_exec = 2'h1,
		st_done = 2'h3
	} exec_state_e;
endpackage : io_group_pkg

// ===== rtl/io_instruction_group_executor.sv
// Purpose: Executes the I/O instruction group on command from AHB-Lite
// Assumes: Channel buffers are external and combinationally readable
// Notes: Writing the instruction register starts one execution
`timescale 1ns/10ps
`default_nettype none
module io_instruction_group_executor #(
	parameter int unsigned CHANNELS = io_group_pkg::CHAN_N
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [io_group_pkg::WORD_W-1:0] chan_in_data,
	input wire logic [CHANNELS-1:0] chan_flag_set,
	output logic [io_group_pkg::SEL_W-1:0] chan_in_sel,
	output io_group_pkg::chan_req_s chan_out,
	output logic [CHANNELS-1:0] chan_flag,
	output logic [CHANNELS-1:0] chan_control,
	output logic intr_enable,
	output logic overflow,
	output logic halted
);
	import io_group_pkg::*;

	// Every select code needs its own flag and control bit
	if (CHANNELS != CHAN_N) begin : g_chan_check
		$error("CHANNELS must equal 64");
	end

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	logic bus_wr, next_bus_wr, bus_rd, next_bus_rd;
	logic [7:0] bus_addr, next_bus_addr;
	logic take;

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
	// Zero wait states, response always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		next_bus_wr = take && hwrite;
		next_bus_rd = take && !hwrite;
		next_bus_addr = take ? haddr[7:0] : bus_addr;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_wr <= 1'b0;
			bus_rd <= 1'b0;
			bus_addr <= 8'h00;
		end else begin
			bus_wr <= next_bus_wr;
			bus_rd <= next_bus_rd;
			bus_addr <= next_bus_addr;
		end
	end

	// ----------------------------------------
	// Processor state
	// ----------------------------------------
	// Programmer-visible registers
	logic [15:0] instr, next_instr;
	logic [15:0] acc_a, next_acc_a;
	logic [15:0] acc_b, next_acc_b;
	logic [15:0] pc, next_pc;
	logic next_overflow, next_intr_enable, next_halted;
	logic [CHANNELS-1:0] next_chan_flag, next_chan_control;
	exec_state_e state, next_state;
	chan_req_s next_chan_out;

	logic [5:0] sel;
	logic [2:0] opf;
	logic use_b, hc, skip, cur_flag, ovf_fn;
	logic [15:0] acc_sel;

	// ----------------------------------------
	// Instruction field decode
	// ----------------------------------------
	// RULE_01 select code
	assign sel = instr[5:0];
	// RULE_03 op and A/B
	assign opf = instr[8:6];
	assign use_b = instr[BIT_AB];
	assign hc = instr[BIT_HC];
	assign acc_sel = use_b ? acc_b : acc_a;
	assign cur_flag = chan_flag[sel];
	assign chan_in_sel = sel;
	assign ovf_fn = (sel == SEL_OVF_FN);

	// ----------------------------------------
	// Execution
	// ----------------------------------------
	always_comb begin
		next_instr = instr;
		next_acc_a = acc_a;
		next_acc_b = acc_b;
		next_pc = pc;
		next_overflow = overflow;
		next_intr_enable = intr_enable;
		next_halted = halted;
		next_chan_control = chan_control;
		next_chan_out = chan_out;
		next_chan_out.write = 1'b0;
		next_state = state;
		skip = 1'b0;
		next_chan_flag = chan_flag;
		// Bus writes reach registers only while idle
		case (state)
		st_idle: begin
			if (bus_wr && bus_addr == OFS_INSTR) begin
				next_instr = hwdata[15:0];
				next_state = st_exec;
			end else if (bus_wr && bus_addr == OFS_ACC_A) begin
				next_acc_a = hwdata[15:0];
			end else if (bus_wr && bus_addr == OFS_ACC_B) begin
				next_acc_b = hwdata[15:0];
			end else if (bus_wr && bus_addr == OFS_PC) begin
				next_pc = hwdata[15:0];
			end else if (bus_wr && bus_addr == OFS_RUN) begin
				next_halted = 1'b0;
			end
		end
		// One cycle of work; results show one edge later
		st_exec: begin
			next_state = st_done;
			next_pc = pc + 16'h0001;
			case (opf)
			op_halt_or_flag: begin
				if (!use_b) begin
					// RULE_05 halt, pc one past
					next_halted = 1'b1;
					if (hc) next_chan_flag[sel] = 1'b0;
				end else if (hc) begin
					// RULE_07 clear flag
					if (sel == SEL_SYSTEM) next_intr_enable = 1'b0;
					else next_chan_flag[sel] = 1'b0;
				end else begin
					// RULE_06 set flag
					if (sel == SEL_SYSTEM) next_intr_enable = 1'b1;
					else next_chan_flag[sel] = 1'b1;
				end
			end
			op_overflow: begin
				if (ovf_fn) begin
					// RULE_15 set or clear overflow
					next_overflow = !use_b;
				end
			end
			op_skip_clear: begin
				if (ovf_fn) begin
					// RULE_17 skip overflow clear
					skip = !overflow;
					// RULE_04 hold or clear overflow
					if (hc) next_overflow = 1'b0;
				end else begin
					// RULE_08 skip if flag clear
					skip = !cur_flag;
					if (hc) next_chan_flag[sel] = 1'b0;
				end
			end
			op_skip_set: begin
				if (ovf_fn) begin
					// RULE_16 skip overflow set
					skip = overflow;
					// Bit 9 acts on overflow, not the flag
					if (hc) next_overflow = 1'b0;
				end else begin
					// RULE_09 skip if flag set
					skip = cur_flag;
					if (hc) next_chan_flag[sel] = 1'b0;
				end
			end
			op_merge: begin
				// RULE_10 merge by OR
				if (use_b) next_acc_b = acc_b | chan_in_data;
				else next_acc_a = acc_a | chan_in_data;
				if (hc) next_chan_flag[sel] = 1'b0;
			end
			op_load: begin
				// RULE_11 load from buffer
				if (use_b) next_acc_b = chan_in_data;
				else next_acc_a = chan_in_data;
				if (hc) next_chan_flag[sel] = 1'b0;
			end
			op_output: begin
				// RULE_12 output accumulator
				next_chan_out.word = acc_sel;
				next_chan_out.sel = sel;
				next_chan_out.write = 1'b1;
				if (hc) next_chan_flag[sel] = 1'b0;
			end
			default: begin
				if (!use_b) begin
					// RULE_13 set control
					next_chan_control[sel] = 1'b1;
				end else if (sel == SEL_SYSTEM) begin
					// RULE_14 clear all from 06
					for (int i = 0; i < CHANNELS; i++) begin
						if (i >= int'(SEL_FIRST_DEV)) begin
							next_chan_control[i] = 1'b0;
						end
					end
				end else begin
					next_chan_control[sel] = 1'b0;
				end
				// RULE_02 hold or clear flag
				if (hc) next_chan_flag[sel] = 1'b0;
			end
			endcase
			// RULE_18 skip adds two
			if (skip) next_pc = pc + 16'h0002;
		end
		default: begin
			next_state = st_idle;
		end
		endcase
		// Device flag raise wins over clear
		next_chan_flag = next_chan_flag | chan_flag_set;
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr <= RST_WORD;
			acc_a <= RST_WORD;
			acc_b <= RST_WORD;
			pc <= RST_WORD;
			overflow <= 1'b0;
			intr_enable <= 1'b0;
			halted <= 1'b0;
			chan_flag <= '0;
			chan_control <= '0;
			chan_out <= '0;
			state <= st_idle;
		end else begin
			instr <= next_instr;
			acc_a <= next_acc_a;
			acc_b <= next_acc_b;
			pc <= next_pc;
			overflow <= next_overflow;
			intr_enable <= next_intr_enable;
			halted <= next_halted;
			chan_flag <= next_chan_flag;
			chan_control <= next_chan_control;
			chan_out <= next_chan_out;
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] next_hrdata;
	// Decoded in the address phase so data stands in the data phase

	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (next_bus_rd) begin
			if (next_bus_addr == OFS_INSTR) begin
				next_hrdata = {16'h0000, instr};
			end else if (next_bus_addr == OFS_ACC_A) begin
				next_hrdata = {16'h0000, acc_a};
			end else if (next_bus_addr == OFS_ACC_B) begin
				next_hrdata = {16'h0000, acc_b};
			end else if (next_bus_addr == OFS_PC) begin
				next_hrdata = {16'h0000, pc};
			end else if (next_bus_addr == OFS_STATUS) begin
				next_hrdata = {28'h0000000, state != st_idle, halted,
					intr_enable, overflow};
			end else if (next_bus_addr == OFS_FLAG_LO) begin
				next_hrdata = chan_flag[31:0];
			end else if (next_bus_addr == OFS_FLAG_HI) begin
				next_hrdata = chan_flag[63:32];
			end else if (next_bus_addr == OFS_CTRL_LO) begin
				next_hrdata = chan_control[31:0];
			end else if (next_bus_addr == OFS_CTRL_HI) begin
				next_hrdata = chan_control[63:32];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end
endmodule : io_instruction_group_executor
`default_nettype wire

// ===== test/io_group_sva.sv
// Purpose: Port checks for the I/O group executor
// Assumes: Zero-wait bus, results two edges after the data phase
// Notes: go marks the data phase of an instruction write
`timescale 1ns/10ps
`default_nettype none
module io_group_sva #(
	parameter int unsigned CHANNELS = 64
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire io_group_pkg::chan_req_s chan_out,
	input wire logic [CHANNELS-1:0] chan_control,
	input wire logic intr_enable,
	input wire logic overflow,
	input wire logic halted
);
	import io_group_pkg::*;
	logic go;
	logic [2:0] op;
	logic [5:0] sel;
	assign op = hwdata[8:6];
	assign sel = hwdata[5:0];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go <= 1'b0;
		end else begin
			go <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
				&& haddr[7:0] == OFS_INSTR;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_OUT_WR: assert property (go && op == 3'h6
		|-> ##2 chan_out.write && chan_out.sel == $past(sel, 2))
		else $error("output op gave no write");
	AST_WR_ONE: assert property (chan_out.write |=> !chan_out.write)
		else $error("write pulse too long");
	AST_STC: assert property (go && op == 3'h7 && !hwdata[11]
		|-> ##2 chan_control[$past(sel, 2)])
		else $error("control bit not set");
	AST_CLC_ALL: assert property (go && op == 3'h7 && hwdata[11]
		&& sel == SEL_SYSTEM |-> ##2 (chan_control >> 6) == '0)
		else $error("control bits left on");
	AST_INT_ON: assert property (go && op == 3'h0 && hwdata[11]
		&& !hwdata[9] && sel == SEL_SYSTEM |-> ##2 intr_enable)
		else $error("interrupts not enabled");
	AST_INT_OFF: assert property (go && op == 3'h0 && hwdata[11]
		&& hwdata[9] && sel == SEL_SYSTEM |-> ##2 !intr_enable)
		else $error("interrupts not disabled");
	AST_OVF: assert property (go && op == 3'h1 && sel == SEL_OVF_FN
		|-> ##2 overflow == !$past(hwdata[11], 2))
		else $error("overflow not updated");
	AST_OVF_HC: assert property (go && op[2:1] == 2'h1
		&& sel == SEL_OVF_FN && hwdata[9] |-> ##2 !overflow)
		else $error("overflow not cleared");
	AST_HALT: assert property (go && op == 3'h0 && !hwdata[11]
		|-> ##2 halted)
		else $error("halt not taken");
	cover property (chan_out.write);
	cover property (go && op == 3'h3);
	cover property ($rose(halted));
endmodule : io_group_sva
bind io_instruction_group_executor io_group_sva #(.CHANNELS(CHANNELS))
	u_io_group_sva (.*);
`default_nettype wire

// ===== test/io_chan_model.sv
// Purpose: Channel buffers seen by the executor
// Assumes: Buffer i resets to a500 plus i
// Notes: Read side is combinational
`timescale 1ns/10ps
`default_nettype none
module io_chan_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [5:0] chan_in_sel,
	input wire io_group_pkg::chan_req_s chan_out,
	output logic [15:0] chan_in_data
);
	import io_group_pkg::*;
	logic [15:0] buf_mem [64];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 64; i++) begin
				buf_mem[i] <= 16'ha500 | 16'(i);
			end
		end else if (chan_out.write) begin
			buf_mem[chan_out.sel] <= chan_out.word;
		end
	end
	assign chan_in_data = buf_mem[chan_in_sel];
endmodule : io_chan_model
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the I/O group executor
// Assumes: Single slave, hready tied to hreadyout
// Notes: Expected values from the decode and buffer reset pattern
`timescale 1ns/10ps
`default_nettype none
module tb;
	import io_group_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic intr_enable, overflow, halted;
	logic [31:0] haddr, hwdata, hrdata, rd, pc0;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] chan_in_data;
	logic [5:0] chan_in_sel;
	logic [63:0] chan_flag_set, chan_flag, chan_control;
	chan_req_s chan_out;
	int err_total, n_tests, cyc;
	io_instruction_group_executor u_io_instruction_group_executor (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .chan_in_data(chan_in_data),
		.chan_flag_set(chan_flag_set), .chan_in_sel(chan_in_sel),
		.chan_out(chan_out), .chan_flag(chan_flag),
		.chan_control(chan_control), .intr_enable(intr_enable),
		.overflow(overflow), .halted(halted));
	io_chan_model u_io_chan_model (.hclk(hclk), .hresetn(hresetn),
		.chan_in_sel(chan_in_sel), .chan_out(chan_out),
		.chan_in_data(chan_in_data));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task automatic check(input string nm, input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : xfer
	function automatic logic [15:0] ins(input logic [2:0] op,
		input logic b11, b9, input logic [5:0] sel);
		return {4'h8, b11, 1'b1, b9, op, sel};
	endfunction : ins
	task automatic run(input logic [15:0] i, input logic [31:0] dpc);
		xfer(OFS_PC, 1'b0, 32'h0);
		pc0 = rd;
		xfer(OFS_INSTR, 1'b1, {16'h0, i});
		repeat (2) @(posedge hclk);
		xfer(OFS_PC, 1'b0, 32'h0);
		check("pc", rd, pc0 + dpc);
	endtask : run
	task automatic t_flag;
		chan_flag_set <= 64'h200;
		@(posedge hclk);
		chan_flag_set <= 64'h0;
		run(ins(3'h0, 1'b1, 1'b0, 6'h05), 1);
		xfer(OFS_FLAG_LO, 1'b0, 32'h0);
		check("flags", rd, 32'h220);
		run(ins(3'h3, 1'b0, 1'b0, 6'h05), 2);
		run(ins(3'h2, 1'b0, 1'b1, 6'h05), 1);
		run(ins(3'h2, 1'b0, 1'b0, 6'h05), 2);
		run(ins(3'h0, 1'b1, 1'b0, 6'h00), 1);
		check("ien", intr_enable, 1);
		run(ins(3'h3, 1'b0, 1'b0, 6'h09), 2);
		run(ins(3'h0, 1'b1, 1'b1, 6'h00), 1);
		check("ien", intr_enable, 0);
		check("flags", chan_flag, 64'h200);
		run(ins(3'h0, 1'b1, 1'b1, 6'h09), 1);
		check("flags", chan_flag, 64'h0);
		$display("test flags done");
	endtask : t_flag
	task automatic t_acc;
		xfer(OFS_ACC_A, 1'b1, 32'h0f0f);
		run(ins(3'h4, 1'b0, 1'b0, 6'h07), 1);
		xfer(OFS_ACC_A, 1'b0, 32'h0);
		check("acc_a", rd, 32'haf0f);
		run(ins(3'h5, 1'b1, 1'b0, 6'h08), 1);
		xfer(OFS_ACC_B, 1'b0, 32'h0);
		check("acc_b", rd, 32'ha508);
		run(ins(3'h6, 1'b0, 1'b0, 6'h14), 1);
		check("out", {chan_out.sel, chan_out.word}, 22'h14af0f);
		run(ins(3'h6, 1'b1, 1'b0, 6'h15), 1);
		run(ins(3'h5, 1'b0, 1'b0, 6'h15), 1);
		xfer(OFS_ACC_A, 1'b0, 32'h0);
		check("acc_a", rd, 32'ha508);
		$display("test acc done");
	endtask : t_acc
	task automatic t_ctrl;
		run(ins(3'h7, 1'b0, 1'b0, 6'h03), 1);
		run(ins(3'h7, 1'b0, 1'b0, 6'h0a), 1);
		run(ins(3'h7, 1'b0, 1'b0, 6'h3f), 1);
		run(ins(3'h7, 1'b1, 1'b0, 6'h00), 1);
		xfer(OFS_CTRL_LO, 1'b0, 32'h0);
		check("ctrl", rd, 32'h8);
		run(ins(3'h7, 1'b1, 1'b0, 6'h03), 1);
		check("ctrl", chan_control, 64'h0);
		$display("test ctrl done");
	endtask : t_ctrl
	task automatic t_ovf;
		run(ins(3'h1, 1'b0, 1'b0, 6'h01), 1);
		run(ins(3'h3, 1'b0, 1'b0, 6'h01), 2);
		run(ins(3'h2, 1'b0, 1'b0, 6'h01), 1);
		run(ins(3'h3, 1'b0, 1'b1, 6'h01), 2);
		check("ovf", overflow, 0);
		run(ins(3'h2, 1'b0, 1'b0, 6'h01), 2);
		run(ins(3'h3, 1'b0, 1'b0, 6'h01), 1);
		run(ins(3'h1, 1'b0, 1'b0, 6'h01), 1);
		run(ins(3'h1, 1'b1, 1'b0, 6'h01), 1);
		check("ovf", overflow, 0);
		$display("test ovf done");
	endtask : t_ovf
	task automatic t_halt;
		run(ins(3'h0, 1'b1, 1'b0, 6'h05), 1);
		run(ins(3'h0, 1'b0, 1'b1, 6'h05), 1);
		check("halt", {halted, chan_flag[5]}, 2'h2);
		xfer(OFS_STATUS, 1'b0, 32'h0);
		check("status", rd, 32'h4);
		xfer(OFS_RUN, 1'b1, 32'h1);
		repeat (2) @(posedge hclk);
		xfer(8'h3c, 1'b0, 32'h0);
		check("unmapped", rd, 32'h0);
		check("run", {halted, hresp}, 2'h0);
		$display("test halt done");
	endtask : t_halt
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_of_test;
		end
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		chan_flag_set = 64'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_flag;
		t_acc;
		t_ctrl;
		t_ovf;
		t_halt;
		end_of_test;
	end
endmodule : tb
`default_nettype wire
